// ==== verilog/seq_stack_regs.svh ====
`ifndef SEQ_STACK_REGS_SVH
`define SEQ_STACK_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------------
`define SLOT_EIGHTEEN_INDEX 6'h32
`define SLOT_NINETEEN_INDEX 6'h33
`define SLOT_TWENTY_INDEX 6'h34
`define SEQ_STATUS_INDEX 6'h3f

// ----------------------------------------------------------------------------
// Field positions inside a stack entry.
// ----------------------------------------------------------------------------
`define DIRECTION_BIT 15
`define OWN_ADDRESS_MSB 14
`define OWN_ADDRESS_LSB 9
`define WRAP_TO_FIRST_BIT 8
`define CONV_B_SEL_MSB 7
`define CONV_B_SEL_LSB 4
`define CONV_A_SEL_MSB 3
`define CONV_A_SEL_LSB 0

// ----------------------------------------------------------------------------
// Reset values of the three entries.
// ----------------------------------------------------------------------------
`define SLOT_EIGHTEEN_RESET 16'h6400
`define SLOT_NINETEEN_RESET 16'h6600
`define SLOT_TWENTY_RESET 16'h6800

`endif

// ==== verilog/seq_stack_pkg.sv ====
package seq_stack_pkg;

    // Active stack entry, one-hot.
    typedef enum logic [2:0] {
        SLOT_18 = 3'b001,
        SLOT_19 = 3'b010,
        SLOT_20 = 3'b100
    } slot_t;

    typedef logic [15:0] entry_t;

endpackage : seq_stack_pkg

// ==== verilog/sequencer_stack_entries.sv ====
`timescale 1ns/1ps
`include "seq_stack_regs.svh"

module sequencer_stack_entries
    import seq_stack_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic CONV_DONE,
    output logic [3:0] CONV_A_SEL,
    output logic [3:0] CONV_B_SEL,
    output logic [2:0] ACTIVE_SLOT
);

    // ------------------------------------------------------------------------
    // Storage and state.
    // ------------------------------------------------------------------------
    // Reset values and word indices of the three entries, first entry first.
    localparam int NUM_SLOTS = 3;
    localparam entry_t SLOT_RESET [NUM_SLOTS] = '{`SLOT_EIGHTEEN_RESET, `SLOT_NINETEEN_RESET, `SLOT_TWENTY_RESET};
    localparam logic [5:0] SLOT_INDEX [NUM_SLOTS] = '{`SLOT_EIGHTEEN_INDEX, `SLOT_NINETEEN_INDEX, `SLOT_TWENTY_INDEX};

    // Registered state, and the combinational next values that feed it.
    entry_t slot_entry [NUM_SLOTS];
    entry_t next_slot_entry [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] slot_hit;
    logic status_hit;
    logic ack;
    logic next_ack;
    logic [31:0] next_readdata;
    logic [31:0] read_word;
    slot_t active;
    slot_t next_active;
    logic [3:0] next_a_sel;
    logic [3:0] next_b_sel;
    logic [1:0] active_idx;
    logic [1:0] target_idx;
    logic wrap_now;

    // ------------------------------------------------------------------------
    // Address decode and bus handshake.
    // ------------------------------------------------------------------------

    // Every access waits exactly one cycle, so the answer comes at the second edge.
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
    assign status_hit = (AVS_ADDRESS == {`SEQ_STATUS_INDEX, 2'b00});

    // Ack rises for one cycle and drops again, so a held request is answered every second cycle.
    always_comb begin
        next_ack = (AVS_READ | AVS_WRITE) & ~ack;
    end

    // Ack only registers its next value.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ack <= 1'b0;
        end else begin
            ack <= next_ack;
        end
    end

    // ------------------------------------------------------------------------
    // Stack entries, one per generate step.
    // ------------------------------------------------------------------------
    // One step per entry: decode, lane writes and the storage itself.
    genvar g;
    generate
        for (g = 0; g < NUM_SLOTS; g++) begin : gen_slot
            assign slot_hit[g] = (AVS_ADDRESS == {SLOT_INDEX[g], 2'b00});

            // All sixteen bits are plain storage, direction and own address included.
            // The block never acts on direction or address; software keeps them for its own use.
            always_comb begin
                next_slot_entry[g] = slot_entry[g];
                if (AVS_WRITE && ack && slot_hit[g]) begin
                    if (AVS_BYTEENABLE[0]) begin
                        next_slot_entry[g][7:0] = AVS_WRITEDATA[7:0];
                    end
                    if (AVS_BYTEENABLE[1]) begin
                        next_slot_entry[g][15:8] = AVS_WRITEDATA[15:8];
                    end
                end
            end

            // Reset loads each entry's own address, so a read shows where the entry sits.
            always_ff @(posedge REF_CLK) begin
                if (!RESET_N) begin
                    slot_entry[g] <= SLOT_RESET[g];
                end else begin
                    slot_entry[g] <= next_slot_entry[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------------

    // Unmapped addresses read as zero and swallow writes, so software never stalls.
    always_comb begin
        read_word = 32'h0000_0000;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (slot_hit[i]) begin
                read_word = {16'h0000, slot_entry[i]};
            end
        end
        if (status_hit) begin
            read_word = {29'h0000_0000, active};
        end
    end

    // The word is captured in the first cycle of a read, while ack is still low,
    // so it already stands at the edge where the master sees waitrequest low.
    always_comb begin
        next_readdata = AVS_READDATA;
        if (AVS_READ && !ack) begin
            next_readdata = read_word;
        end
    end

    // Read data only registers; it holds between reads.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            AVS_READDATA <= 32'h0000_0000;
        end else begin
            AVS_READDATA <= next_readdata;
        end
    end

    // ------------------------------------------------------------------------
    // Sequencer walk.
    // ------------------------------------------------------------------------
    // Index of the running entry; an illegal code falls back to the first one.
    always_comb begin
        unique case (active)
            SLOT_18: active_idx = 2'd0;
            SLOT_19: active_idx = 2'd1;
            SLOT_20: active_idx = 2'd2;
            default: active_idx = 2'd0;
        endcase
    end

    // The wrap flag of the running entry decides where the walk goes next.
    assign wrap_now = slot_entry[active_idx][`WRAP_TO_FIRST_BIT];

    // Past the last entry there is nothing left, so the walk wraps to the first.
    always_comb begin
        next_active = active;
        if (CONV_DONE) begin
            if (wrap_now) begin
                next_active = SLOT_18;
            end else begin
                unique case (active)
                    SLOT_18: next_active = SLOT_19;
                    SLOT_19: next_active = SLOT_20;
                    SLOT_20: next_active = SLOT_18;
                    default: next_active = SLOT_18;
                endcase
            end
        end
    end

    // Index of the entry about to run, read for its selections.
    always_comb begin
        unique case (next_active)
            SLOT_18: target_idx = 2'd0;
            SLOT_19: target_idx = 2'd1;
            SLOT_20: target_idx = 2'd2;
            default: target_idx = 2'd0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Converter selects.
    // ------------------------------------------------------------------------

    // Selections are latched at the boundary; a write to the active entry
    // takes effect only when that entry is entered again.
    always_comb begin
        next_a_sel = CONV_A_SEL;
        next_b_sel = CONV_B_SEL;
        if (CONV_DONE) begin
            next_a_sel = slot_entry[target_idx][`CONV_A_SEL_MSB:`CONV_A_SEL_LSB];
            next_b_sel = slot_entry[target_idx][`CONV_B_SEL_MSB:`CONV_B_SEL_LSB];
        end
    end

    // Walk state and both selects register together, so they never disagree.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            active <= SLOT_18;
            CONV_A_SEL <= 4'h0;
            CONV_B_SEL <= 4'h0;
        end else begin
            active <= next_active;
            CONV_A_SEL <= next_a_sel;
            CONV_B_SEL <= next_b_sel;
        end
    end

    // The one-hot state is shown as it stands, for software and the converters.
    assign ACTIVE_SLOT = active;

endmodule : sequencer_stack_entries

// ==== sim/seq_chk.sv ====
`timescale 1ns/1ps
`include "seq_stack_regs.svh"
// ------
// Checker.
// ------
module seq_chk
    import seq_stack_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic CONV_DONE,
    input wire logic [3:0] CONV_A_SEL,
    input wire logic [3:0] CONV_B_SEL,
    input wire logic [2:0] ACTIVE_SLOT
);
    entry_t ent [3];
    logic [1:0] idx, cur, nx;
    logic hit, w;
    logic [3:0] na, nb;
    // Next entry and its selects, worked out from a shadow of the stack.
    assign idx = 2'(AVS_ADDRESS[7:2] - 6'h32);
    assign hit = AVS_ADDRESS inside {8'hc8, 8'hcc, 8'hd0};
    assign cur = ACTIVE_SLOT[2] ? 2'd2 : {1'b0, ACTIVE_SLOT[1]};
    assign w = ent[cur][`WRAP_TO_FIRST_BIT];
    assign nx = (w || cur == 2'd2) ? 2'd0 : cur + 2'd1;
    assign {nb, na} = ent[nx][7:0];
    // Lanes land only on the accepting edge, so a read in flight never sees half a write.
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ent <= '{`SLOT_EIGHTEEN_RESET, `SLOT_NINETEEN_RESET, `SLOT_TWENTY_RESET};
        end else if (AVS_WRITE && !AVS_WAITREQUEST && hit) begin
            if (AVS_BYTEENABLE[0]) ent[idx][7:0] <= AVS_WRITEDATA[7:0];
            if (AVS_BYTEENABLE[1]) ent[idx][15:8] <= AVS_WRITEDATA[15:8];
        end
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    wait_one_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus wait longer than one cycle");
    read_back_a: assert property (AVS_READ && !AVS_WAITREQUEST && hit |-> AVS_READDATA == {16'h0000, ent[idx]})
        else $error("entry read back differs");
    unmapped_a: assert property (AVS_READ && !AVS_WAITREQUEST && !hit && AVS_ADDRESS != 8'hfc |-> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    advance_a: assert property (CONV_DONE && !w |=> ACTIVE_SLOT == 3'b001 << $past(nx))
        else $error("stack did not advance");
    wrap_first_a: assert property (CONV_DONE && w |=> ACTIVE_SLOT == SLOT_18)
        else $error("stack did not wrap");
    b_sel_a: assert property (CONV_DONE |=> CONV_B_SEL == $past(nb))
        else $error("converter b select wrong");
    a_sel_a: assert property (CONV_DONE |=> CONV_A_SEL == $past(na))
        else $error("converter a select wrong");
    sel_hold_a: assert property (!CONV_DONE |=> $stable(CONV_A_SEL) && $stable(CONV_B_SEL) && $stable(ACTIVE_SLOT))
        else $error("selects moved mid conversion");
    cover property (CONV_DONE && w);
    cover property (CONV_DONE && cur == 2'd2);
    cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule : seq_chk

bind sequencer_stack_entries seq_chk u_chk (.*);

// ==== sim/sequencer_stack_entries_bench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", n, e, g); end end
// ------
// Bench.
// ------
module sequencer_stack_entries_bench
    import seq_stack_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, done = 1'b0, wait_req;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0] be = 4'h3, sel_a, sel_b;
    logic [2:0] slot;
    int error_cnt = 0, checks = 0, cyc = 0;
    sequencer_stack_entries dut (.REF_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_req),
        .CONV_DONE(done), .CONV_A_SEL(sel_a), .CONV_B_SEL(sel_b), .ACTIVE_SLOT(slot));
    // Clock, and a ceiling far above the sixty-six cycles the tests need.
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            print_verdict;
        end
    end
    // The request stands until the edge that sees waitrequest low.
    task bus(input bit w, input [7:0] a, input [31:0] d, input [3:0] b);
        @(posedge clk);
        {adr, wr, rd, wdat, be} <= {a, w, !w, d, b};
        do @(posedge clk); while (wait_req !== 1'b0);
        q = rdat;
        {rd, wr} <= 2'b00;
    endtask : bus
    task rdchk(input [7:0] a, input [31:0] e, input string n);
        bus(0, a, 32'h0, 4'h3);
        `CHK(n, e, q)
    endtask : rdchk
    task pulse(input slot_t s, input [3:0] ea, input [3:0] eb);
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        #1;
        `CHK("slot", s, slot)
        `CHK("sel", {eb, ea}, {sel_b, sel_a})
    endtask : pulse
    task print_verdict;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    // Reset values, lane writes, a walk round the stack, writes to the running entry and a wrap from the middle.
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(8'hc8, 32'h6400, "e18");
        rdchk(8'hcc, 32'h6600, "e19");
        rdchk(8'hd0, 32'h6800, "e20");
        rdchk(8'hd4, 32'h0, "unmapped");
        `CHK("sel", 8'h00, {sel_b, sel_a})
        $display("test reset done");
        bus(1, 8'hc8, 32'h0000_e421, 4'h3);
        bus(1, 8'hcc, 32'h0000_6643, 4'h3);
        bus(1, 8'hd0, 32'hffff_ff65, 4'h1);
        bus(1, 8'hd0, 32'h0000_6900, 4'h2);
        rdchk(8'hc8, 32'he421, "w18");
        rdchk(8'hd0, 32'h6965, "w20");
        $display("test write done");
        pulse(SLOT_19, 4'h3, 4'h4);
        pulse(SLOT_20, 4'h5, 4'h6);
        pulse(SLOT_18, 4'h1, 4'h2);
        rdchk(8'hfc, 32'h1, "status");
        bus(1, 8'hcc, 32'h0000_66a9, 4'h3);
        bus(1, 8'hc8, 32'h0000_64b7, 4'h3);
        #1;
        `CHK("hold", 8'h21, {sel_b, sel_a})
        pulse(SLOT_19, 4'h9, 4'ha);
        $display("test sequence done");
        bus(1, 8'hcc, 32'h0000_6700, 4'h2);
        #1;
        `CHK("hold", 8'ha9, {sel_b, sel_a})
        pulse(SLOT_18, 4'h7, 4'hb);
        bus(1, 8'hd0, 32'h0000_6800, 4'h2);
        bus(1, 8'hcc, 32'h0000_6600, 4'h2);
        pulse(SLOT_19, 4'h9, 4'ha);
        pulse(SLOT_20, 4'h5, 4'h6);
        pulse(SLOT_18, 4'h7, 4'hb);
        $display("test wrap done");
        print_verdict;
    end
endmodule : sequencer_stack_entries_bench
